// >>> rtl/dbs_async_fifo.sv
// Dual-clock FIFO with gray-coded pointers and a registered read port
`timescale 1ns/1ps
module dbs_async_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Filling side
   input wire logic wr_clk,
   input wire logic wr_rst_n,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [WIDTH-1:0] wr_data,
   // Draining side
   input wire logic rd_clk,
   input wire logic rd_rst_n,
   input wire logic rd_en,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [WIDTH-1:0] rd_data
);
   localparam int PW = $clog2(DEPTH);

   // Gray full test needs a power of two and at least four entries
   if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("dbs_async_fifo: DEPTH must be a power of two of at least 4");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW:0] wbin_q, wbin_d, wgray_q, wgray_d, rg1_q, rg2_q;
   logic [PW:0] rbin_q, rbin_d, rgray_q, rgray_d, wg1_q, wg2_q;
   logic out_valid_q, out_valid_d;
   logic [WIDTH-1:0] rd_data_q, rd_data_d;
   logic push, full, empty, load;

   // Write pointer; full when the synced read pointer differs only in the top two bits
   always_comb begin
      full = (wgray_q == {~rg2_q[PW:PW-1], rg2_q[PW-2:0]});
      wr_ready = ~full;
      push = wr_valid & ~full;
      wbin_d = wbin_q + (PW+1)'(push);
      wgray_d = wbin_d ^ (wbin_d >> 1);
   end

   always_ff @(posedge wr_clk or negedge wr_rst_n) begin
      if (!wr_rst_n) begin
         wbin_q <= '0;
         wgray_q <= '0;
         rg1_q <= '0;
         rg2_q <= '0;
      end else begin
         wbin_q <= wbin_d;
         wgray_q <= wgray_d;
         rg1_q <= rgray_q;
         rg2_q <= rg1_q;
      end
   end

   // Storage has no reset; contents are only read behind the pointers
   always_ff @(posedge wr_clk) begin
      if (push) begin
         mem_q[wbin_q[PW-1:0]] <= wr_data;
      end
   end

   // Read side refills its output register whenever it is empty or being taken
   always_comb begin
      empty = (rgray_q == wg2_q);
      load = ~empty & (~out_valid_q | rd_ready);
      rbin_d = rbin_q + (PW+1)'(load);
      rgray_d = rbin_d ^ (rbin_d >> 1);
      rd_data_d = load ? mem_q[rbin_q[PW-1:0]] : rd_data_q;
      out_valid_d = load | (out_valid_q & ~rd_ready);
   end

   always_ff @(posedge rd_clk or negedge rd_rst_n) begin
      if (!rd_rst_n) begin
         rbin_q <= '0;
         rgray_q <= '0;
         wg1_q <= '0;
         wg2_q <= '0;
         out_valid_q <= 1'b0;
         rd_data_q <= '0;
      end else if (rd_en) begin
         rbin_q <= rbin_d;
         rgray_q <= rgray_d;
         wg1_q <= wgray_q;
         wg2_q <= wg1_q;
         out_valid_q <= out_valid_d;
         rd_data_q <= rd_data_d;
      end
   end

   assign rd_valid = out_valid_q;
   assign rd_data = rd_data_q;
endmodule

// >>> rtl/dbs_pkg.sv
// Shared constants, carriers and states of the burst-of-two SRAM port
package dbs_pkg;
   // Geometry of the default variant
   localparam int DBS_DATA_W = 18;
   localparam int DBS_ADDR_W = 10;
   localparam int DBS_BYTE_W = 9;
   localparam int DBS_BYTES = DBS_DATA_W / DBS_BYTE_W;
   localparam int DBS_FIFO_DEPTH = 16;
   localparam int DBS_SYNC_STAGES = 2;

   // Reset values
   localparam logic [DBS_DATA_W-1:0] DBS_DQ_RST = 18'h00000;
   localparam logic [DBS_ADDR_W-1:0] DBS_ADDR_RST = 10'h000;
   localparam logic [DBS_BYTES-1:0] DBS_BE_RST = 2'h0;

   // Command taken from the address pins on an accepting edge
   typedef struct packed {
      logic valid;
      logic rd;
      logic [DBS_ADDR_W-1:0] addr;
   } dbs_cmd_s;

   // One buffered write: address, both words and their byte enables
   typedef struct packed {
      logic [DBS_ADDR_W-1:0] addr;
      logic [DBS_BYTES-1:0] be1;
      logic [DBS_DATA_W-1:0] w1;
      logic [DBS_BYTES-1:0] be0;
      logic [DBS_DATA_W-1:0] w0;
   } dbs_wr_req_s;

   localparam int DBS_WR_REQ_W = $bits(dbs_wr_req_s);

   localparam dbs_cmd_s DBS_CMD_RST = '{valid: 1'b0, rd: 1'b0, addr: DBS_ADDR_RST};
   localparam dbs_wr_req_s DBS_REQ_RST = '{addr: DBS_ADDR_RST, be1: DBS_BE_RST,
                                           w1: DBS_DQ_RST, be0: DBS_BE_RST, w0: DBS_DQ_RST};

   // Self-timed array write sequencer
   typedef enum logic [2:0] {
      DBS_DR_IDLE = 3'b001,
      DBS_DR_LO = 3'b010,
      DBS_DR_HI = 3'b100
   } dbs_drain_e;
endpackage

// >>> rtl/dbs_sram_port.sv
// Double-data-rate burst-of-two SRAM port with buffered self-timed writes
// Notes on behaviour
// - An address is taken only on every other rising edge of the true input clock.
// - Write words are sampled on the rising edges of the true and complementary clocks.
// - Read words are launched on the rising edges of the true and complementary clocks.
// - Each address holds two words that always move in the same order, word0 then word1.
// - With latency select high the first read word appears 2.5 cycles after the address.
// - With latency select low the first read word appears one cycle after the address.
// - The read valid flag is high exactly while read words sit on the data pins.
// - The echo clocks are edge-aligned with the read data.
// - Every synchronous pin is registered by the true or complementary clock.
// - Every data output comes from a register on the true or complementary clock.
// - Apart from reset, only rising edges of the two input clocks and of sys_clk sample or change anything.
// - A registered write that the buffer accepts finishes in the array on its own without controller action.
// - The data pins are driven by the memory only in read phases, by the controller in writes.
`timescale 1ns/1ps
module dbs_sram_port
   import dbs_pkg::*;
#(
   parameter int DATA_W = DBS_DATA_W,
   parameter int ADDR_W = DBS_ADDR_W,
   parameter int FIFO_DEPTH = DBS_FIFO_DEPTH
) (
   // Internal clock for the self-timed write engine
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Input clock pair from the controller
   input wire logic k_clk,
   input wire logic k_n_clk,
   // Command and address pins
   input wire logic load_n,
   input wire logic read_not_write,
   input wire logic [ADDR_W-1:0] addr,
   // Shared data pins, split into in, out and enable
   input wire logic [DATA_W-1:0] dq_i,
   output logic [DATA_W-1:0] dq_o,
   output logic dq_oe_n,
   input wire logic [DBS_BYTES-1:0] byte_write_select_n,
   // Static latency strap
   input wire logic latency_select,
   // Echo clocks and flags
   output logic echo_clock,
   output logic echo_clock_n,
   output logic read_valid_flag,
   output logic write_ready
);
   localparam int LANES = 2 * DBS_BYTES;

   // Carriers are fixed in the package, so the widths must agree with it
   if (DATA_W != DBS_DATA_W || ADDR_W != DBS_ADDR_W) begin : g_bad_width
      $error("dbs_sram_port: DATA_W and ADDR_W must match the package carriers");
   end

   // Lanes are whole bytes of the package byte width
   if (DATA_W % DBS_BYTE_W != 0) begin : g_bad_lane
      $error("dbs_sram_port: DATA_W must be a whole number of byte lanes");
   end

   // Gray pointers in the write buffer need a power of two of at least four
   if (FIFO_DEPTH < 4 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("dbs_sram_port: FIFO_DEPTH must be a power of two of at least 4");
   end

   // True-clock state
   dbs_cmd_s cmd_q, cmd_d;
   logic rd1_q, rd1_d, rd2_q, rd2_d, wr1_q, wr1_d;
   logic [2*DATA_W-1:0] rd_word_q, rd_word_d, stage2_q, stage2_d, arr_rd;
   logic [DATA_W-1:0] w0_q, w0_d, q_k_q, q_k_d;
   logic [DBS_BYTES-1:0] be0_q, be0_d;
   logic [ADDR_W-1:0] waddr_q, waddr_d;
   logic vk_q, vk_d;
   // Strap synchroniser
   logic lat_meta_q, lat_meta_d, lat_q, lat_d;
   // Complementary-clock state
   logic [DATA_W-1:0] w1_q, w1_d, q_kn_q, q_kn_d;
   logic [DBS_BYTES-1:0] be1_q, be1_d;
   logic vkn_q, vkn_d;
   // Write buffer and drain engine
   dbs_wr_req_s push_req, pop_req, req_q, req_d;
   logic fifo_wr_ready, fifo_rd_valid, fifo_rd_ready;
   dbs_drain_e dr_q, dr_d;
   logic [LANES-1:0] lane_we;

   // The array has no read bypass: a read of a burst still waiting in the write
   // buffer returns the old words, so a controller leaves a short gap first
   // Array: one narrow memory per byte lane, written on sys_clk, read on k_clk
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      logic [DBS_BYTE_W-1:0] lane_q [2**ADDR_W];
      logic [DBS_BYTE_W-1:0] lane_wd;

      // Lanes below DBS_BYTES belong to word0, the rest to word1
      if (l < DBS_BYTES) begin : g_w0
         assign lane_wd = req_q.w0[l*DBS_BYTE_W +: DBS_BYTE_W];
         assign lane_we[l] = (dr_q == DBS_DR_LO) & req_q.be0[l];
      end else begin : g_w1
         assign lane_wd = req_q.w1[(l-DBS_BYTES)*DBS_BYTE_W +: DBS_BYTE_W];
         assign lane_we[l] = (dr_q == DBS_DR_HI) & req_q.be1[l-DBS_BYTES];
      end

      // A lane whose select is off keeps its old contents
      always_ff @(posedge sys_clk) begin
         if (clk_en && lane_we[l]) begin
            lane_q[req_q.addr] <= lane_wd;
         end
      end

      // Asynchronous array read, registered by the true clock before use
      assign arr_rd[l*DBS_BYTE_W +: DBS_BYTE_W] = lane_q[cmd_q.addr];
   end

   // Strap is static but still crosses in through two flops
   always_comb begin
      lat_meta_d = latency_select;
      lat_d = lat_meta_q;
   end

   // Only the second flop is read by the pipeline
   always_ff @(posedge k_clk or negedge rst_n) begin
      if (!rst_n) begin
         lat_meta_q <= 1'b0;
         lat_q <= 1'b0;
      end else begin
         lat_meta_q <= lat_meta_d;
         lat_q <= lat_d;
      end
   end

   // Read walk with the address taken at true edge e:
   //   long latency: e+1 word pair read, e+2 staged, complementary edge e+2.5 word0
   //   and the flag, true edge e+3 word1, complementary edge e+3.5 the flag drops;
   //   short latency: e+1 word0 and the flag, e+1.5 word1, e+2 the flag drops.
   // The next command comes at e+2 at the earliest, so the stages never collide.
   // True-clock pipeline: command capture, array read, word0/word1 launch
   always_comb begin
      // Accept only when the previous edge did not, so one address per burst
      cmd_d.valid = ~load_n & ~cmd_q.valid;
      cmd_d.rd = read_not_write;
      cmd_d.addr = addr;
      // Read and write markers ride one cycle behind the command
      rd1_d = cmd_q.valid & cmd_q.rd;
      wr1_d = cmd_q.valid & ~cmd_q.rd;
      rd2_d = rd1_q;
      // Word pair is registered once, then staged again for the long latency
      rd_word_d = arr_rd;
      stage2_d = rd_word_q;
      // Word0 of a write arrives on the true edge after its address
      w0_d = wr1_d ? dq_i : w0_q;
      be0_d = wr1_d ? ~byte_write_select_n : be0_q;
      waddr_d = wr1_d ? cmd_q.addr : waddr_q;
      if (lat_q) begin
         // Long latency: word1 on the true edge three cycles after the address
         vk_d = rd2_q;
         q_k_d = stage2_q[DATA_W +: DATA_W];
      end else begin
         // Short latency: word0 straight from the array one cycle on
         vk_d = rd1_d;
         q_k_d = arr_rd[0 +: DATA_W];
      end
   end

   // Registers only; every next value comes from the block above
   always_ff @(posedge k_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_q <= DBS_CMD_RST;
         rd1_q <= 1'b0;
         rd2_q <= 1'b0;
         wr1_q <= 1'b0;
         rd_word_q <= '0;
         stage2_q <= '0;
         w0_q <= DBS_DQ_RST;
         be0_q <= DBS_BE_RST;
         waddr_q <= DBS_ADDR_RST;
         vk_q <= 1'b0;
         q_k_q <= DBS_DQ_RST;
      end else begin
         cmd_q <= cmd_d;
         rd1_q <= rd1_d;
         rd2_q <= rd2_d;
         wr1_q <= wr1_d;
         rd_word_q <= rd_word_d;
         stage2_q <= stage2_d;
         w0_q <= w0_d;
         be0_q <= be0_d;
         waddr_q <= waddr_d;
         vk_q <= vk_d;
         q_k_q <= q_k_d;
      end
   end

   // Complementary-clock half: word1 capture on writes, the other read word
   always_comb begin
      w1_d = wr1_q ? dq_i : w1_q;
      be1_d = wr1_q ? ~byte_write_select_n : be1_q;
      if (lat_q) begin
         // Long latency: word0 half a cycle before the true-edge word1
         vkn_d = rd2_q;
         q_kn_d = stage2_q[0 +: DATA_W];
      end else begin
         vkn_d = rd1_q;
         q_kn_d = rd_word_q[DATA_W +: DATA_W];
      end
   end

   // Complementary-edge registers, reset like the true-clock ones
   always_ff @(posedge k_n_clk or negedge rst_n) begin
      if (!rst_n) begin
         w1_q <= DBS_DQ_RST;
         be1_q <= DBS_BE_RST;
         vkn_q <= 1'b0;
         q_kn_q <= DBS_DQ_RST;
      end else begin
         w1_q <= w1_d;
         be1_q <= be1_d;
         vkn_q <= vkn_d;
         q_kn_q <= q_kn_d;
      end
   end

   // Pins show whichever register launched last: high phase follows the true edge
   // The select is the clock itself, so the pins move only at a rising edge of either clock
   always_comb begin
      dq_o = k_clk ? q_k_q : q_kn_q;
      read_valid_flag = k_clk ? vk_q : vkn_q;
      dq_oe_n = ~read_valid_flag;
      echo_clock = k_clk;
      echo_clock_n = k_n_clk;
   end

   // Write walk: word0 and its selects are taken at true edge e+1, word1 at the
   // complementary edge e+1.5, and the whole burst enters the buffer at e+2
   // Complete write enters the buffer one true edge after word1 was taken
   always_comb begin
      push_req.addr = waddr_q;
      push_req.be1 = be1_q;
      push_req.w1 = w1_q;
      push_req.be0 = be0_q;
      push_req.w0 = w0_q;
   end

   // Depth sets how many bursts may wait while the engine is frozen or busy
   // Writes cross to sys_clk here; a controller ignoring write_ready loses the burst
   dbs_async_fifo #(
      .WIDTH(DBS_WR_REQ_W),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .wr_clk(k_clk),
      .wr_rst_n(rst_n),
      .wr_valid(wr1_q),
      .wr_ready(fifo_wr_ready),
      .wr_data(push_req),
      .rd_clk(sys_clk),
      .rd_rst_n(rst_n),
      .rd_en(clk_en),
      .rd_valid(fifo_rd_valid),
      .rd_ready(fifo_rd_ready),
      .rd_data(pop_req)
   );

   assign write_ready = fifo_wr_ready;

   // Self-timed engine: pops one burst, writes word0 lanes then word1 lanes
   always_comb begin
      dr_d = dr_q;
      req_d = req_q;
      fifo_rd_ready = 1'b0;
      unique case (dr_q)
         DBS_DR_IDLE: begin
            fifo_rd_ready = 1'b1;
            if (fifo_rd_valid) begin
               req_d = pop_req;
               dr_d = DBS_DR_LO;
            end
         end
         DBS_DR_LO: begin
            // Word0 lanes are written in this cycle
            dr_d = DBS_DR_HI;
         end
         DBS_DR_HI: begin
            // Word1 lanes are written in this cycle
            dr_d = DBS_DR_IDLE;
         end
         default: begin
            dr_d = DBS_DR_IDLE;
         end
      endcase
   end

   // Clock enable freezes only this domain; the pin side keeps running on the
   // input clocks, so bursts keep arriving and pile up in the buffer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dr_q <= DBS_DR_IDLE;
         req_q <= DBS_REQ_RST;
      end else if (clk_en) begin
         dr_q <= dr_d;
         req_q <= req_d;
      end
   end
endmodule

// >>> verification/dbs_ctrl_model.sv
// Behavioural memory controller facing the burst SRAM port
`timescale 1ns/1ps
module dbs_ctrl_model
   import dbs_pkg::*;
(
   // Input clock pair
   input wire logic k_clk,
   input wire logic k_n_clk,
   // Command pins
   output logic load_n,
   output logic read_not_write,
   output logic [DBS_ADDR_W-1:0] addr,
   // Data pins and byte selects
   output logic [DBS_DATA_W-1:0] dq_i,
   input wire logic [DBS_DATA_W-1:0] dq_o,
   input wire logic dq_oe_n,
   output logic [DBS_BYTES-1:0] byte_write_select_n,
   // Echo side
   input wire logic echo_clock,
   input wire logic echo_clock_n,
   input wire logic read_valid_flag
);
   logic [DBS_DATA_W-1:0] got_q[$];
   dbs_wr_req_s wq[$];
   logic [DBS_DATA_W-1:0] own_d, idle_d;
   logic own, acc, took;
   int ph;
   // Pin level: our word, the memory's word, or a pattern that never settles
   assign dq_i = own ? own_d : (dq_oe_n ? idle_d : dq_o);
   initial begin
      load_n = 1'b1;
      read_not_write = 1'b1;
      addr = '0;
      own = 1'b0;
      own_d = '0;
      idle_d = '0;
      acc = 1'b0;
      ph = 0;
      byte_write_select_n = '1;
   end
   // Word0 after the address edge, word1 after the next true edge
   always @(posedge k_clk) begin
      took = !load_n && !acc && !read_not_write;
      acc = !load_n && !acc;
      #0.5;
      idle_d = ~idle_d;
      if (ph == 1) begin
         own_d = wq[0].w1;
         byte_write_select_n = wq[0].be1;
         ph = 2;
      end
      if (took) begin
         own = 1'b1;
         own_d = wq[0].w0;
         byte_write_select_n = wq[0].be0;
         ph = 1;
      end
   end
   // Release the pins once word1 has been sampled
   always @(posedge k_n_clk) begin
      #0.5;
      idle_d = ~idle_d;
      if (ph == 2) begin
         own = 1'b0;
         byte_write_select_n = '1;
         ph = 0;
         void'(wq.pop_front());
      end
   end
   // Qualify by the flag mid-word, never by counting latency
   always @(posedge echo_clock or posedge echo_clock_n) begin
      #3;
      if (read_valid_flag === 1'b1) got_q.push_back(dq_o);
   end
   // One command; hold above 1 keeps the strobe low into the refused edge
   task automatic cmd(input logic rd, input dbs_wr_req_s r, input int hold);
      @(posedge k_clk);
      #0.5;
      if (!rd) wq.push_back(r);
      load_n = 1'b0;
      read_not_write = rd;
      addr = r.addr;
      repeat (hold) @(posedge k_clk);
      #0.5;
      load_n = 1'b1;
      addr = ~addr;
   endtask
endmodule

// >>> verification/dbs_sram_port_assertions.sv
// Pin-level checks of the burst SRAM port
`timescale 1ns/1ps
module dbs_sram_port_chk (
   // Clocks and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic k_clk,
   input wire logic k_n_clk,
   // Command and strap
   input wire logic load_n,
   input wire logic read_not_write,
   input wire logic latency_select,
   // Outputs watched
   input wire logic dq_oe_n,
   input wire logic echo_clock,
   input wire logic echo_clock_n,
   input wire logic read_valid_flag,
   input wire logic write_ready
);
   logic acc_q, rd_q, acc_d, rd_d;
   // An edge right after a taken command never takes one
   always_comb begin
      acc_d = !load_n && !acc_q;
      rd_d = acc_d && read_not_write;
   end
   // Taken-command history on the true clock
   always_ff @(posedge k_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         rd_q <= rd_d;
      end
   end
   sequence s_rd_long;
      rd_q && latency_select;
   endsequence
   sequence s_rd_short;
      rd_q && !latency_select;
   endsequence
   a_oe_true_edge: assert property (@(posedge k_clk) disable iff (!rst_n)
      dq_oe_n == !read_valid_flag) else $error("data enable differs from valid flag");
   a_oe_comp_edge: assert property (@(posedge k_n_clk) disable iff (!rst_n)
      dq_oe_n == !read_valid_flag) else $error("data enable differs from valid flag");
   a_echo_aligned: assert property (@(posedge sys_clk) disable iff (!rst_n)
      echo_clock == k_clk && echo_clock_n == k_n_clk) else $error("echo clocks off");
   a_lat_long: assert property (@(posedge k_n_clk) disable iff (!rst_n)
      s_rd_long |-> ##2 !read_valid_flag ##1 read_valid_flag) else $error("long latency off");
   a_lat_short: assert property (@(posedge k_n_clk) disable iff (!rst_n)
      s_rd_short |-> !read_valid_flag ##1 read_valid_flag) else $error("short latency off");
   a_valid_needs_read: assert property (@(posedge k_n_clk) disable iff (!rst_n)
      (!rd_q) [*4] |-> !read_valid_flag) else $error("valid flag without a read");
   a_ready_drains: assert property (@(posedge k_clk) disable iff (!rst_n)
      (clk_en && !write_ready) [*8] |-> 1'b0) else $error("write buffer never drains");
   a_ready_reset: assert property (@(posedge k_clk) disable iff (!rst_n)
      $rose(rst_n) |-> write_ready) else $error("buffer not empty after reset");
endmodule
bind dbs_sram_port dbs_sram_port_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
   .k_clk(k_clk), .k_n_clk(k_n_clk), .load_n(load_n), .read_not_write(read_not_write),
   .latency_select(latency_select), .dq_oe_n(dq_oe_n), .echo_clock(echo_clock),
   .echo_clock_n(echo_clock_n), .read_valid_flag(read_valid_flag), .write_ready(write_ready));

// >>> verification/test_ddr_burst2_sram_port.sv
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ps
module test_ddr_burst2_sram_port;
   import dbs_pkg::*;
   logic sys_clk, rst_n, clk_en, k_clk, k_n_clk, load_n, read_not_write, latency_select;
   logic dq_oe_n, echo_clock, echo_clock_n, read_valid_flag, write_ready;
   logic [DBS_ADDR_W-1:0] addr;
   logic [DBS_DATA_W-1:0] dq_i, dq_o;
   logic [DBS_BYTES-1:0] byte_write_select_n;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   dbs_sram_port u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .k_clk(k_clk),
      .k_n_clk(k_n_clk), .load_n(load_n), .read_not_write(read_not_write), .addr(addr),
      .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .byte_write_select_n(byte_write_select_n),
      .latency_select(latency_select), .echo_clock(echo_clock), .echo_clock_n(echo_clock_n),
      .read_valid_flag(read_valid_flag), .write_ready(write_ready));
   dbs_ctrl_model u_ctrl (.k_clk(k_clk), .k_n_clk(k_n_clk), .load_n(load_n),
      .read_not_write(read_not_write), .addr(addr), .dq_i(dq_i), .dq_o(dq_o),
      .dq_oe_n(dq_oe_n), .byte_write_select_n(byte_write_select_n), .echo_clock(echo_clock),
      .echo_clock_n(echo_clock_n), .read_valid_flag(read_valid_flag));
   // Two unrelated clocks; the complement is exact
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      k_clk = 1'b0;
      #1.3;
      forever #7.5 k_clk = ~k_clk;
   end
   assign k_n_clk = ~k_clk;
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // A hang ends the run as a failure
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Words carry their address so misplaced data shows up
   function automatic dbs_wr_req_s req(input logic [9:0] a, input logic [7:0] v);
      req = '{addr: a, be1: 2'h0, w1: {~v, a}, be0: 2'h0, w0: {v, a}};
   endfunction
   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      u_ctrl.cmd(1'b0, req(a, v), 1);
   endtask
   task automatic rd(input logic [9:0] a);
      u_ctrl.cmd(1'b1, req(a, 8'h00), 1);
   endtask
   // Both words of one burst, in order, within a bounded wait
   task automatic expect_rd(input logic [9:0] a, input logic [7:0] v);
      dbs_wr_req_s r;
      r = req(a, v);
      repeat (20) if (u_ctrl.got_q.size() < 2) @(posedge k_clk);
      check("word0", u_ctrl.got_q.pop_front(), r.w0);
      check("word1", u_ctrl.got_q.pop_front(), r.w1);
   endtask
   task automatic t_long();
      wr(10'h001, 8'h11);
      wr(10'h002, 8'h22);
      repeat (8) @(posedge k_clk);
      rd(10'h001);
      rd(10'h002);
      expect_rd(10'h001, 8'h11);
      expect_rd(10'h002, 8'h22);
   endtask
   task automatic t_refuse();
      u_ctrl.cmd(1'b1, req(10'h001, 8'h00), 2);
      expect_rd(10'h001, 8'h11);
      repeat (6) @(posedge k_clk);
      check("extra words", 18'(u_ctrl.got_q.size()), 18'h0);
   endtask
   task automatic t_short();
      #0.5;
      latency_select = 1'b0;
      repeat (3) @(posedge k_clk);
      rd(10'h002);
      rd(10'h001);
      expect_rd(10'h002, 8'h22);
      expect_rd(10'h001, 8'h11);
      #0.5;
      latency_select = 1'b1;
      repeat (3) @(posedge k_clk);
   endtask
   // Frozen drain fills the buffer; the burst beyond it is dropped
   task automatic t_full();
      @(posedge sys_clk);
      #0.5;
      clk_en = 1'b0;
      for (int i = 0; i < 16; i++) wr(10'(16 + i), 8'(i));
      repeat (2) @(posedge k_clk);
      #1;
      check("ready full", 18'(write_ready), 18'h0);
      wr(10'h001, 8'h99);
      @(posedge sys_clk);
      #0.5;
      clk_en = 1'b1;
      repeat (30) @(posedge k_clk);
      #1;
      check("ready drained", 18'(write_ready), 18'h1);
      rd(10'h010);
      rd(10'h01f);
      rd(10'h001);
      expect_rd(10'h010, 8'h00);
      expect_rd(10'h01f, 8'h0f);
      expect_rd(10'h001, 8'h11);
   endtask
   // Word0 keeps its masked upper lane, word1 takes all its new lanes
   task automatic t_bytes();
      dbs_wr_req_s r;
      r = req(10'h010, 8'h5a);
      r.be0 = 2'h2;
      u_ctrl.cmd(1'b0, r, 1);
      repeat (8) @(posedge k_clk);
      rd(10'h010);
      repeat (20) if (u_ctrl.got_q.size() < 2) @(posedge k_clk);
      check("masked word0", u_ctrl.got_q.pop_front(), {8'h00, 10'h010});
      check("masked word1", u_ctrl.got_q.pop_front(), {8'ha5, 10'h010});
   endtask
   // Reset in mid-read clears the outputs but not the array
   task automatic t_reset();
      rd(10'h002);
      repeat (2) @(posedge k_clk);
      #0.5;
      rst_n = 1'b0;
      #1;
      check("oe in reset", 18'(dq_oe_n), 18'h1);
      check("valid in reset", 18'(read_valid_flag), 18'h0);
      check("ready in reset", 18'(write_ready), 18'h1);
      repeat (16) @(posedge sys_clk);
      #0.5;
      rst_n = 1'b1;
      u_ctrl.got_q.delete();
      repeat (3) @(posedge k_clk);
      rd(10'h002);
      expect_rd(10'h002, 8'h22);
   endtask
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      latency_select = 1'b1;
      repeat (16) @(posedge sys_clk);
      #0.5;
      rst_n = 1'b1;
      repeat (3) @(posedge k_clk);
      t_long();
      t_refuse();
      t_short();
      t_full();
      t_bytes();
      t_reset();
      end_of_test();
   end
endmodule
